// [design/rtca_consts.svh]
`ifndef RTCA_CONSTS_SVH
`define RTCA_CONSTS_SVH
// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define RTCA_IDX_AEN 8'hec
`define RTCA_IDX_CTL 8'hed
`define RTCA_ADDR_AEN 12'h3b0
`define RTCA_ADDR_CTL 12'h3b4
`define RTCA_ADDR_STS 12'h3b8
`define RTCA_ADDR_MSK 12'h3bc
// ----------------------------------------
// control bit positions
// ----------------------------------------
`define RTCA_CTL_ALARM 7
`define RTCA_CTL_INTEN 6
`define RTCA_CTL_BCD 5
`define RTCA_CTL_SRC 4
`define RTCA_CTL_LRATE 3
`define RTCA_CTL_WAKE 1
`define RTCA_CTL_UNLOCK 0
// ----------------------------------------
// reset values and divisors
// ----------------------------------------
`define RTCA_AEN_RST 4'h0
`define RTCA_DIV_XTAL 16'h8000
`define RTCA_DIV_LINE60 16'h003c
`define RTCA_DIV_LINE50 16'h0032
`endif

// [design/rtca_pkg.sv]
package rtca_pkg;
    // four compared time fields, one byte each
    typedef struct packed {
        logic [7:0] dow;
        logic [7:0] hrs;
        logic [7:0] min;
        logic [7:0] sec;
    } rtca_time_s;
    // apb request
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rtca_apb_s;
    typedef enum logic {RTCA_IDLE, RTCA_DONE} rtca_bus_e;
endpackage

// [design/rtca_ctrl.sv]
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "rtca_consts.svh"
// Overview of operation
// - alarm enables reset zero, upper nibble zero
// - per-field enable includes field in matching
// - control read clears alarm flag and its request, not status bits
// - flag evaluated on lock or count increment
// - control write restarts the prescaler
// - wake cause survives reset, cleared on read
// - decimal enable selects bcd counting
// - crystal source: oscillator on, divide 32768
// - line source: oscillator off, rate bit divisor
// - reset clears bits 6,0; keeps 7,5..2
// - bit 7 reads zero without alarm
// - bit 7 reads one while alarm pending
// - bit 6 gates the alarm flag interrupt, not masked status
// - time counters writable only when unlocked
module rtca_ctrl (
    input wire logic ref_clk_i, // 50 mhz clock
    input wire logic rst_i, // system reset, sync high
    input wire logic por_i, // power-on reset, sync high
    input wire rtca_pkg::rtca_apb_s apb_i, // apb request
    input wire rtca_pkg::rtca_time_s now_i, // current time fields
    input wire rtca_pkg::rtca_time_s alm_i, // alarm set points
    input wire logic count_inc_i, // time count increment pulse
    input wire logic src_tick_i, // source clock tick pulse
    input wire logic sleep_i, // cpu is in sleep mode
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error, unmapped address
    output logic [31:0] prdata_o, // apb read data
    output logic irq_o, // level interrupt
    output logic wake_o, // wake request to cpu
    output logic sec_tick_o, // one-second pulse
    output logic osc_en_o, // crystal oscillator enable
    output logic bcd_en_o, // decimal counting mode
    output logic time_wr_en_o // time counters writable
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [3:0] aen_r; // alarm field enables
    logic alarm_r; // alarm flag
    logic inten_r; // alarm interrupt enable
    logic [3:0] cfg_r; // bcd, source, rate, spare
    logic wake_r; // sleep wake cause
    logic unlock_r; // write unlock
    logic [1:0] sts_r; // sticky events: wake, alarm
    logic [1:0] msk_r; // event mask
    logic [15:0] pre_r; // prescaler count
    rtca_pkg::rtca_bus_e bus_r; // apb phase
    logic acc; // access phase completing
    logic wr_ctl, rd_ctl, wr_aen, wr_sts, wr_msk;
    logic match; // alarm condition
    logic eval; // flag re-evaluation event
    logic wake_set; // alarm ends sleep
    logic [15:0] div; // active divisor
    logic [31:0] rd_nxt; // read mux

    // equality on one field, gated by its enable
    function automatic logic fld_ok(input logic en, input logic [7:0] a, input logic [7:0] b);
        fld_ok = !en || (a == b);
    endfunction

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    // one wait state so ready and data come from flops
    always_comb begin
        acc = apb_i.psel && apb_i.penable && (bus_r == rtca_pkg::RTCA_DONE);
        wr_ctl = acc && apb_i.pwrite && apb_i.paddr == `RTCA_ADDR_CTL;
        rd_ctl = acc && !apb_i.pwrite && apb_i.paddr == `RTCA_ADDR_CTL;
        wr_aen = acc && apb_i.pwrite && apb_i.paddr == `RTCA_ADDR_AEN;
        wr_sts = acc && apb_i.pwrite && apb_i.paddr == `RTCA_ADDR_STS;
        wr_msk = acc && apb_i.pwrite && apb_i.paddr == `RTCA_ADDR_MSK;
    end

    // ready handshake
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bus_r <= rtca_pkg::RTCA_IDLE;
            pready_o <= 1'b0;
        end else begin
            case (bus_r)
                rtca_pkg::RTCA_IDLE: begin
                    // answer in the cycle after penable rises
                    if (apb_i.psel && apb_i.penable) begin
                        bus_r <= rtca_pkg::RTCA_DONE;
                        pready_o <= 1'b1;
                    end
                end
                rtca_pkg::RTCA_DONE: begin
                    bus_r <= rtca_pkg::RTCA_IDLE;
                    pready_o <= 1'b0;
                end
                default: begin
                    bus_r <= rtca_pkg::RTCA_IDLE;
                    pready_o <= 1'b0;
                end
            endcase
        end
    end

    // read mux, reserved bits read zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (apb_i.paddr)
            `RTCA_ADDR_AEN: rd_nxt[3:0] = aen_r;
            `RTCA_ADDR_CTL: begin
                rd_nxt[`RTCA_CTL_ALARM] = alarm_r;
                rd_nxt[`RTCA_CTL_INTEN] = inten_r;
                rd_nxt[5:2] = cfg_r;
                rd_nxt[`RTCA_CTL_WAKE] = wake_r;
                rd_nxt[`RTCA_CTL_UNLOCK] = unlock_r;
            end
            `RTCA_ADDR_STS: rd_nxt[1:0] = sts_r;
            `RTCA_ADDR_MSK: rd_nxt[1:0] = msk_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // read data and error, loaded as ready rises
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (apb_i.psel && apb_i.penable && bus_r == rtca_pkg::RTCA_IDLE) begin
            prdata_o <= apb_i.pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr_o <= !(apb_i.paddr == `RTCA_ADDR_AEN || apb_i.paddr == `RTCA_ADDR_CTL ||
                           apb_i.paddr == `RTCA_ADDR_STS || apb_i.paddr == `RTCA_ADDR_MSK);
        end else begin
            pslverr_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // alarm enables
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            aen_r <= `RTCA_AEN_RST;
        end else if (wr_aen) begin
            aen_r <= apb_i.pwdata[3:0];
        end
    end

    // ----------------------------------------
    // control bits
    // ----------------------------------------
    // bits 5..2 only follow power-on, a system reset keeps them
    always_ff @(posedge ref_clk_i) begin
        if (por_i) begin
            cfg_r <= 4'h0;
        end else if (wr_ctl) begin
            cfg_r <= apb_i.pwdata[5:2];
        end
    end

    // bits 6 and 0 are cleared by system reset
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || por_i) begin
            inten_r <= 1'b0;
            unlock_r <= 1'b0;
        end else if (wr_ctl) begin
            inten_r <= apb_i.pwdata[`RTCA_CTL_INTEN];
            unlock_r <= apb_i.pwdata[`RTCA_CTL_UNLOCK];
        end
    end

    // ----------------------------------------
    // alarm matching and flag
    // ----------------------------------------
    always_comb begin
        match = fld_ok(aen_r[3], now_i.dow, alm_i.dow) && fld_ok(aen_r[2], now_i.hrs, alm_i.hrs) &&
                fld_ok(aen_r[1], now_i.min, alm_i.min) && fld_ok(aen_r[0], now_i.sec, alm_i.sec);
        // locking write or count step, nothing else
        eval = count_inc_i || (wr_ctl && unlock_r && !apb_i.pwdata[`RTCA_CTL_UNLOCK]);
        wake_set = eval && match && sleep_i;
    end

    // flag kept over system reset; a set beats a same-cycle read clear
    always_ff @(posedge ref_clk_i) begin
        if (por_i) begin
            alarm_r <= 1'b0;
        end else if (eval && match) begin
            alarm_r <= 1'b1;
        end else if (rd_ctl) begin
            alarm_r <= 1'b0;
        end
    end

    // wake cause survives system reset for software to inspect
    always_ff @(posedge ref_clk_i) begin
        if (por_i) begin
            wake_r <= 1'b0;
        end else if (wake_set) begin
            wake_r <= 1'b1;
        end else if (rd_ctl) begin
            wake_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sts_r <= 2'h0;
            msk_r <= 2'h0;
        end else begin
            // write one to clear, a new event wins
            sts_r <= (sts_r & ~(wr_sts ? apb_i.pwdata[1:0] : 2'h0)) | {wake_set, eval && match};
            if (wr_msk) begin
                msk_r <= apb_i.pwdata[1:0];
            end
        end
    end

    // alarm path drops one cycle after the flag clears
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o <= (alarm_r && inten_r) || |(sts_r & msk_r);
            wake_o <= wake_set;
        end
    end

    // ----------------------------------------
    // prescaler and mode outputs
    // ----------------------------------------
    always_comb begin
        if (!cfg_r[`RTCA_CTL_SRC - 2]) begin
            div = `RTCA_DIV_XTAL;
        end else begin
            div = cfg_r[`RTCA_CTL_LRATE - 2] ? `RTCA_DIV_LINE50 : `RTCA_DIV_LINE60;
        end
    end

    // any control write restarts the second so software can align it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || wr_ctl) begin
            pre_r <= 16'h0000;
            sec_tick_o <= 1'b0;
        end else if (src_tick_i) begin
            pre_r <= (pre_r == div - 16'h0001) ? 16'h0000 : pre_r + 16'h0001;
            sec_tick_o <= (pre_r == div - 16'h0001);
        end else begin
            sec_tick_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            osc_en_o <= 1'b0;
            bcd_en_o <= 1'b0;
            time_wr_en_o <= 1'b0;
        end else begin
            osc_en_o <= !cfg_r[`RTCA_CTL_SRC - 2];
            bcd_en_o <= cfg_r[`RTCA_CTL_BCD - 2];
            time_wr_en_o <= unlock_r;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_aen_reset;
        @(posedge ref_clk_i) rst_i |=> aen_r == 4'h0;
    endproperty
    a_aen_reset: assert property (p_aen_reset) else $error("enables not cleared");

    property p_rd_clears;
        @(posedge ref_clk_i) disable iff (rst_i || por_i) rd_ctl && !(eval && match) |=> !alarm_r;
    endproperty
    a_rd_clears: assert property (p_rd_clears) else $error("read left flag set");

    property p_irq_drop;
        @(posedge ref_clk_i) disable iff (rst_i || por_i) rd_ctl && !(eval && match) && msk_r == 2'h0 |=> ##1 !irq_o;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("alarm irq not withdrawn");

    property p_flag_only_eval;
        @(posedge ref_clk_i) disable iff (rst_i || por_i) !alarm_r && !eval |=> !alarm_r;
    endproperty
    a_flag_only_eval: assert property (p_flag_only_eval) else $error("flag set outside event");

    property p_pre_restart;
        @(posedge ref_clk_i) disable iff (rst_i) wr_ctl |=> pre_r == 16'h0000 && !sec_tick_o;
    endproperty
    a_pre_restart: assert property (p_pre_restart) else $error("prescaler not restarted");

    property p_wake_keep;
        @(posedge ref_clk_i) disable iff (por_i) wake_r && rst_i && !rd_ctl |=> wake_r;
    endproperty
    a_wake_keep: assert property (p_wake_keep) else $error("wake lost on reset");

    property p_xtal;
        @(posedge ref_clk_i) disable iff (rst_i) !cfg_r[2] |-> div == 16'h8000 ##1 osc_en_o;
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal setup wrong");

    property p_line;
        @(posedge ref_clk_i) disable iff (rst_i) cfg_r[2] |-> div == (cfg_r[1] ? 16'h0032 : 16'h003c) ##1 !osc_en_o;
    endproperty
    a_line: assert property (p_line) else $error("line setup wrong");

    property p_rst_bits;
        @(posedge ref_clk_i) rst_i |=> !inten_r && !unlock_r;
    endproperty
    a_rst_bits: assert property (p_rst_bits) else $error("bits 6,0 not cleared");

    property p_irq_gate;
        @(posedge ref_clk_i) disable iff (rst_i) !inten_r && msk_r == 2'h0 |=> !irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
endmodule // rtca_ctrl

// [verification/rtca_ctrl_tb.sv]
`timescale 1ns/1ps
`include "rtca_consts.svh"
module rtca_ctrl_tb;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic ref_clk_i, rst_i, por_i, count_inc_i, src_tick_i, sleep_i; // driven inputs
    rtca_pkg::rtca_apb_s apb_i; // apb request
    rtca_pkg::rtca_time_s now_i, alm_i; // compared time fields
    logic pready_o, pslverr_o, irq_o, wake_o, sec_tick_o, osc_en_o, bcd_en_o, time_wr_en_o;
    logic [31:0] prdata_o, rd; // read data, last taken word
    logic err; // last taken error response
    int n_errors, total_checks, n_sec, n_wake; // counters
    rtca_ctrl i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .por_i(por_i), .apb_i(apb_i), .now_i(now_i),
        .alm_i(alm_i), .count_inc_i(count_inc_i), .src_tick_i(src_tick_i), .sleep_i(sleep_i),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .irq_o(irq_o), .wake_o(wake_o),
        .sec_tick_o(sec_tick_o), .osc_en_o(osc_en_o), .bcd_en_o(bcd_en_o), .time_wr_en_o(time_wr_en_o));
    // 50 mhz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // pulse outputs last one cycle, so count them at every edge
    always @(posedge ref_clk_i) begin
        if (sec_tick_o === 1'b1) n_sec++;
        if (wake_o === 1'b1) n_wake++;
    end
    // ----------------------------------------
    // helper tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        apb_i.psel <= 1'b1;
        apb_i.penable <= 1'b0;
        apb_i.pwrite <= wr;
        apb_i.paddr <= a;
        apb_i.pwdata <= d;
        @(posedge ref_clk_i);
        apb_i.penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk_i);
            if (pready_o === 1'b1) break;
        end
        if (k == 20) begin
            n_errors++; // a hung slave ends the run at once
            close_out();
        end
        rd = prdata_o;
        err = pslverr_o;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
        @(posedge ref_clk_i); // keeps the next setup off this edge
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    // one count increment, then time for the flag to settle
    task automatic bump();
        count_inc_i <= 1'b1;
        @(posedge ref_clk_i);
        count_inc_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask
    // source ticks every other cycle, as a real source clock would be slower
    task automatic ticks(input int n);
        repeat (n) begin
            src_tick_i <= 1'b1;
            @(posedge ref_clk_i);
            src_tick_i <= 1'b0;
            @(posedge ref_clk_i);
        end
        repeat (3) @(posedge ref_clk_i);
    endtask
    task automatic sys_reset();
        rst_i <= 1'b1;
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_i, por_i, count_inc_i, src_tick_i, sleep_i} = 5'h18;
        apb_i = '0;
        alm_i = 32'h03122345;
        now_i = 32'h03122345;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        @(posedge ref_clk_i);
        rdchk("aen_reset", `RTCA_ADDR_AEN, 32'h0);
        rdchk("ctl_reset", `RTCA_ADDR_CTL, 32'h0);
        apb(1'b1, `RTCA_ADDR_AEN, 32'hff);
        rdchk("aen_rw", `RTCA_ADDR_AEN, 32'h0f);
        // crystal source divides by the full count
        chk("osc_on", 32'h1, {31'h0, osc_en_o});
        apb(1'b1, `RTCA_ADDR_CTL, 32'h0);
        n_sec = 0;
        ticks(32767);
        chk("xtal_early", 32'h0, n_sec);
        ticks(1);
        chk("xtal_sec", 32'h1, n_sec);
        // line source at 60, restarted midway by a control write
        apb(1'b1, `RTCA_ADDR_CTL, 32'h10);
        @(posedge ref_clk_i); // mode outputs are one flop behind the control bits
        chk("osc_off", 32'h0, {31'h0, osc_en_o});
        n_sec = 0;
        ticks(30);
        apb(1'b1, `RTCA_ADDR_CTL, 32'h10);
        ticks(59);
        chk("restart", 32'h0, n_sec);
        ticks(1);
        chk("line60", 32'h1, n_sec);
        apb(1'b1, `RTCA_ADDR_CTL, 32'h18);
        n_sec = 0;
        ticks(49);
        chk("line50_early", 32'h0, n_sec);
        ticks(1);
        chk("line50", 32'h1, n_sec);
        // configuration survives a system reset, enables do not
        apb(1'b1, `RTCA_ADDR_CTL, 32'h7d);
        @(posedge ref_clk_i); // let the registered mode outputs follow
        chk("bcd_on", 32'h1, {31'h0, bcd_en_o});
        chk("unlocked", 32'h1, {31'h0, time_wr_en_o});
        sys_reset();
        rdchk("ctl_keep", `RTCA_ADDR_CTL, 32'h3c);
        chk("locked", 32'h0, {31'h0, time_wr_en_o});
        rdchk("aen_cleared", `RTCA_ADDR_AEN, 32'h0);
        apb(1'b1, `RTCA_ADDR_CTL, 32'h0);
        @(posedge ref_clk_i); // let the registered mode outputs follow
        chk("bcd_off", 32'h0, {31'h0, bcd_en_o});
        // each field: a mismatch blocks when enabled, is ignored when not
        for (int i = 0; i < 4; i++) begin
            now_i <= alm_i ^ (32'h1 << (8 * i));
            apb(1'b1, `RTCA_ADDR_AEN, 32'h1 << i);
            bump();
            rdchk("field_on", `RTCA_ADDR_CTL, 32'h0);
            apb(1'b1, `RTCA_ADDR_AEN, 32'hf ^ (32'h1 << i));
            bump();
            rdchk("field_off", `RTCA_ADDR_CTL, 32'h80);
            rdchk("read_clears", `RTCA_ADDR_CTL, 32'h0);
        end
        // no evaluation without an event, then the lock event
        apb(1'b1, `RTCA_ADDR_AEN, 32'hf);
        bump();
        now_i <= alm_i;
        repeat (4) @(posedge ref_clk_i);
        rdchk("no_event", `RTCA_ADDR_CTL, 32'h0);
        apb(1'b1, `RTCA_ADDR_CTL, 32'h1);
        apb(1'b1, `RTCA_ADDR_CTL, 32'h0);
        rdchk("lock_eval", `RTCA_ADDR_CTL, 32'h80);
        // interrupt enable gates the request; read withdraws it
        apb(1'b1, `RTCA_ADDR_CTL, 32'h40);
        bump();
        chk("irq_on", 32'h1, {31'h0, irq_o});
        rdchk("ctl_pending", `RTCA_ADDR_CTL, 32'hc0);
        repeat (2) @(posedge ref_clk_i);
        chk("irq_read_off", 32'h0, {31'h0, irq_o});
        apb(1'b1, `RTCA_ADDR_CTL, 32'h0);
        bump();
        chk("irq_gated", 32'h0, {31'h0, irq_o});
        rdchk("ctl_flag", `RTCA_ADDR_CTL, 32'h80);
        // sticky status with mask, cleared by writing one
        apb(1'b1, `RTCA_ADDR_STS, 32'h3);
        rdchk("sts_clear", `RTCA_ADDR_STS, 32'h0);
        apb(1'b1, `RTCA_ADDR_MSK, 32'h1);
        bump();
        chk("irq_mask_on", 32'h1, {31'h0, irq_o});
        rdchk("sts_set", `RTCA_ADDR_STS, 32'h1);
        apb(1'b1, `RTCA_ADDR_STS, 32'h1);
        repeat (2) @(posedge ref_clk_i);
        chk("irq_w1c", 32'h0, {31'h0, irq_o});
        apb(1'b1, `RTCA_ADDR_MSK, 32'h0);
        rdchk("ctl_drain", `RTCA_ADDR_CTL, 32'h80);
        // wake cause from sleep survives the following reset
        sleep_i <= 1'b1;
        n_wake = 0;
        bump();
        sleep_i <= 1'b0;
        chk("wake_pulse", 32'h1, n_wake);
        sys_reset();
        rdchk("wake_kept", `RTCA_ADDR_CTL, 32'h82);
        rdchk("wake_read", `RTCA_ADDR_CTL, 32'h0);
        // unmapped address is refused
        apb(1'b0, 12'h3c0, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        close_out();
    end
endmodule // rtca_ctrl_tb
